/* File: bench/meas_engine.sv */
// Behavioural measurement engine standing at the far side of the command block.
// Assumes one clock shared with the block; burst and gap come from the bench.
`timescale 1ns/1ps

module meas_engine (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic meas_start,
	input wire logic [7:0] burst,
	input wire logic [3:0] gap,
	output logic meas_done,
	output logic [31:0] meas_value
);
	logic [7:0] left; // Readings still owed
	logic [3:0] wait_cnt; // Idle cycles before next reading
	logic [31:0] idx; // Readings made so far

	// ==========================================================
	// Start, pace and deliver readings
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			left <= 8'h00;
			wait_cnt <= 4'h0;
			idx <= 32'h0;
			meas_done <= 1'b0;
			meas_value <= 32'h0;
		end else begin
			meas_done <= 1'b0;
			// Value line inverts every cycle between pulses, alternating the last reading and its inverse
			meas_value <= ~meas_value;
			if (meas_start) begin
				left <= burst;
				wait_cnt <= gap;
			end else if (left != 8'h00 && wait_cnt != 4'h0) begin
				wait_cnt <= wait_cnt - 4'h1;
			end else if (left != 8'h00) begin
				// One reading, value follows the count
				meas_done <= 1'b1;
				meas_value <= 32'h5a000000 + idx * 32'h3;
				idx <= idx + 32'h1;
				left <= left - 8'h01;
				wait_cnt <= gap;
			end
		end
	end
endmodule

/* File: bench/reading_trigger_fetch_logic_test.sv */
// Self-checking bench: AHB-Lite host driving commands, engine model behind.
// Assumes the params header on the include path; seed fixed for repeatability.
`timescale 1ns/1ps
`include "meter_cmd_params.svh"

module reading_trigger_fetch_logic_test;
	import meter_cmd_pkg::*;
	logic hclk = 1'b0; // Bus clock
	logic hresetn, hsel, hwrite, hreadyout, hresp, meas_done, meas_start;
	logic [31:0] haddr, hwdata, hrdata, meas_value, q;
	logic [1:0] htrans;
	logic [2:0] hsize;
	wire logic hready; // Single slave drives the bus ready
	logic rab, auto_rearm, ocomp, lvo, rtd_user, rate_slow, rate_medium, rate_fast;
	func_t cur_func;
	unit_t temp_unit, sim_ref_unit;
	jsrc_t jss;
	logic [15:0] sim_ref_value, v;
	logic [7:0] burst;
	logic [3:0] gap, fsel;
	int n_fail = 0, tests_run = 0, seed, cyc = 0, n_start = 0, n_done = 0, n0, d0;
	logic [23:0] units [5] = '{`UNIT_C, `UNIT_CEL, `UNIT_F, `UNIT_FAR, `UNIT_K};
	unit_t uexp [5] = '{U_CEL, U_CEL, U_FAR, U_FAR, U_KEL};
	logic [15:0] apers [4];
	logic [2:0] rexp [4] = '{3'b100, 3'b010, 3'b001, 3'b000};
	localparam logic [23:0] QS = {`QUOTE_SINGLE, 16'h0}; // Single-quoted name
	localparam logic [23:0] QD = {`QUOTE_DOUBLE, 16'h0}; // Double-quoted name

	assign hready = hreadyout;

	meter_cmd i_meter_cmd (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .meas_done(meas_done),
		.meas_value(meas_value), .meas_start(meas_start), .reading_available_bit(rab),
		.auto_rearm(auto_rearm), .cur_func(cur_func), .offset_compensation(ocomp),
		.low_voltage_ohms(lvo), .temp_unit(temp_unit), .junction_source_select(jss),
		.sim_ref_value(sim_ref_value), .sim_ref_unit(sim_ref_unit), .rtd_user(rtd_user),
		.rate_slow(rate_slow), .rate_medium(rate_medium), .rate_fast(rate_fast));
	meas_engine i_meas_engine (.clk(hclk), .rst_n(hresetn), .meas_start(meas_start),
		.burst(burst), .gap(gap), .meas_done(meas_done), .meas_value(meas_value));

	// ==========================================================
	// Clock, watchdog and pulse counters
	initial begin
		forever #2.5 hclk = ~hclk;
	end
	always @(posedge hclk) begin
		cyc++;
		if (meas_start === 1'b1) n_start++;
		if (meas_done === 1'b1) n_done++;
		if (cyc == 30000) begin
			n_fail++;
			conclude();
		end
	end

	// ==========================================================
	// Helpers
	function logic [31:0] rv(input int i); // Reading number i of the engine
		return 32'h5a000000 + 32'(i * 3);
	endfunction
	function logic [23:0] ch(input logic [2:0] s, input logic [7:0] lo); // Channel arg
		return {12'h0, s, 1'b1, lo};
	endfunction
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One single transfer: address phase, then data phase
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		q = hrdata;
	endtask
	task rd(input logic [7:0] a);
		xfer(1'b0, a, 32'h0);
	endtask
	task cmd(input cmd_t op, input logic [23:0] arg);
		xfer(1'b1, `ADDR_CMD, {op, arg});
	endtask
	// Error flag and code, then clear the flag
	task err(input logic [15:0] code);
		rd(`ADDR_STATUS);
		chk(q[5], code != `ERR_NONE);
		if (code != `ERR_NONE) begin
			rd(`ADDR_ERROR);
			chk(q[15:0], code);
			xfer(1'b1, `ADDR_ERROR, 32'h0);
		end
	endtask
	task idle(); // Bounded wait for measurements to finish
		for (int i = 0; i < 100; i++) begin
			rd(`ADDR_STATUS);
			if (q[0] === 1'b0) break;
		end
	endtask
	task conclude();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		seed = 69373;
		{hresetn, hsel, haddr, htrans, hwrite, hwdata} = '0;
		hsize = 3'h2;
		burst = 8'h01;
		gap = 4'h2;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
		// Reset defaults
		rd(`ADDR_STATUS);
		chk(q[1], 1'b0);
		chk(q[23:16], `RST_SAMPLES);
		chk({rate_slow, rtd_user}, 2'b10);
		// Fetch with nothing stored
		n0 = n_start;
		cmd(OP_FETCH, 24'h0);
		err(`ERR_STALE);
		chk(n_start, n0);
		// Function names in either quote, bad quote refused
		for (int k = 0; k < 6; k++) begin
			fsel = 4'(($random(seed) & 32'hff) % 12);
			cmd(OP_FUNC, (k[0] ? QS : QD) | {20'h0, fsel});
			rd(`ADDR_STATUS);
			chk(cur_func, fsel);
		end
		cmd(OP_FUNC, 24'h410001);
		err(`ERR_SYNTAX);
		// Ohms options outside four-wire apply later
		cmd(OP_FUNC, QS);
		cmd(OP_OFFSET_COMPENSATION, 24'h1);
		cmd(OP_LVOHM, 24'h1);
		err(`ERR_NONE);
		chk({ocomp, lvo}, 2'b00);
		cmd(OP_FUNC, QS | 24'h5);
		rd(`ADDR_STATUS);
		chk({ocomp, lvo}, 2'b11);
		// Channel offset compensation needs four-wire channel first
		cmd(OP_FUNC, QD | ch(3'h2, 8'h0));
		cmd(OP_OFFSET_COMPENSATION, ch(3'h2, 8'h1));
		err(`ERR_SCANFUNC);
		cmd(OP_FUNC, QS | ch(3'h0, 8'h5));
		cmd(OP_OFFSET_COMPENSATION, ch(3'h0, 8'h1));
		err(`ERR_NONE);
		chk(q[9], 1'b1);
		// External junction needs thermistor or four-wire RTD channel
		cmd(OP_FUNC, QS | ch(3'h3, 8'h0));
		cmd(OP_JSRC, ch(3'h3, 8'h2));
		err(`ERR_CONFLICT);
		chk(jss, JS_SIM);
		for (int k = 9; k < 11; k++) begin
			cmd(OP_JSRC, 24'h1);
			cmd(OP_FUNC, QS | ch(3'h3, 8'(k)));
			cmd(OP_JSRC, ch(3'h3, 8'h2));
			err(`ERR_NONE);
			chk(jss, JS_EXT);
		end
		// Unit codes and simulated junction units
		for (int k = 0; k < 5; k++) begin
			v = 16'($random(seed));
			cmd(OP_UNIT, units[k]);
			cmd(OP_JSIM, {8'h0, v});
			rd(`ADDR_STATUS);
			chk(temp_unit, uexp[k]);
			chk({sim_ref_unit, sim_ref_value}, {uexp[k], v});
		end
		// Any coefficient selects the user type
		for (int k = 0; k < 4; k++) begin
			cmd(OP_RTDCOEF, {6'h0, 2'(k), 16'($random(seed))});
			rd(`ADDR_STATUS);
			chk(rtd_user, 1'b1);
		end
		// Gate time to rate lamps
		apers = '{`APER_SLOW_MS, `APER_MED_MS, `APER_FAST_MS, 16'h5000 | 16'($random(seed))};
		for (int k = 0; k < 4; k++) begin
			cmd(OP_APER, {8'h0, apers[k]});
			rd(`ADDR_STATUS);
			chk({rate_slow, rate_medium, rate_fast}, rexp[k]);
		end
		// Multi-sample initiate, busy refusal, fetch and buffer
		burst = 8'h03;
		gap = 4'h9;
		n0 = n_start;
		d0 = n_done;
		cmd(OP_SAMPLE, 24'h3);
		cmd(OP_INIT, 24'h0);
		cmd(OP_INIT, 24'h0);
		err(`ERR_INIT_IGN);
		chk(n_start, n0 + 1);
		idle();
		chk(n_done, d0 + 3);
		chk(rab, 1'b1);
		cmd(OP_FETCH, 24'h0);
		err(`ERR_NONE);
		chk(q[27:24], 4'h3);
		rd(`ADDR_READING);
		chk(q, rv(d0 + 2));
		for (int k = 0; k < 3; k++) begin
			rd(8'h20 + 8'(4 * k));
			chk(q, rv(d0 + k));
		end
		// Latest repeats, fresh only once, neither triggers
		for (int k = 0; k < 2; k++) begin
			cmd(OP_LATEST, 24'h0);
			rd(`ADDR_READING);
			chk(q, rv(d0 + 2));
		end
		cmd(OP_FRESH, 24'h0);
		err(`ERR_NONE);
		cmd(OP_FRESH, 24'h0);
		err(`ERR_STALE);
		chk(n_start, n0 + 1);
		// Range and function changes invalidate the stored reading
		cmd(OP_RANGE, 24'h0);
		rd(`ADDR_STATUS);
		chk(q[4], 1'b0);
		cmd(OP_FETCH, 24'h0);
		err(`ERR_STALE);
		burst = 8'h01;
		cmd(OP_SAMPLE, 24'h1);
		cmd(OP_INIT, 24'h0);
		idle();
		cmd(OP_FUNC, QS | 24'h1);
		cmd(OP_FETCH, 24'h0);
		err(`ERR_STALE);
		// Store lock refuses multi-sample initiate and read
		cmd(OP_STORE, 24'h1);
		cmd(OP_SAMPLE, 24'h2);
		n0 = n_start;
		cmd(OP_INIT, 24'h0);
		err(`ERR_MEMORY);
		cmd(OP_READ, 24'h0);
		err(`ERR_MEMORY);
		chk(n_start, n0);
		cmd(OP_SAMPLE, 24'h1);
		cmd(OP_INIT, 24'h0);
		err(`ERR_NONE);
		idle();
		cmd(OP_STORE, 24'h0);
		// Read refused on bus or external trigger, then answered
		for (int k = 1; k < 3; k++) begin
			cmd(OP_TRIGSRC, 24'(k));
			cmd(OP_READ, 24'h0);
			err(`ERR_DEADLOCK);
		end
		cmd(OP_TRIGSRC, 24'h0);
		gap = 4'h0;
		d0 = n_done;
		cmd(OP_READ, 24'h0);
		idle();
		chk(q[7], 1'b1);
		rd(`ADDR_READING);
		chk(q, rv(d0));
		rd(`ADDR_STATUS);
		chk(q[7], 1'b0);
		// Sample count versus rearm, preset and reset defaults
		cmd(OP_SAMPLE, 24'h2);
		cmd(OP_CONT, 24'h1);
		err(`ERR_CONFLICT);
		cmd(OP_SAMPLE, 24'h1);
		cmd(OP_CONT, 24'h1);
		err(`ERR_NONE);
		cmd(OP_SAMPLE, 24'h2);
		err(`ERR_CONFLICT);
		cmd(OP_CONT, 24'h0);
		cmd(OP_PRESET, 24'h0);
		rd(`ADDR_STATUS);
		chk(auto_rearm, 1'b1);
		cmd(OP_RESET, 24'h0);
		idle();
		chk(auto_rearm, 1'b0);
		conclude();
	end
endmodule

/* File: logic/meter_cmd.sv */
// Command interpreter for measurement setup, triggering and reading retrieval.
// Assumes an AHB-Lite master as sole master and a measurement engine on hclk.
//
// The AHB-Lite slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "meter_cmd_params.svh"

module meter_cmd (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic meas_done,
	input wire logic [31:0] meas_value,
	output logic meas_start,
	output logic reading_available_bit,
	output logic auto_rearm,
	output meter_cmd_pkg::func_t cur_func,
	output logic offset_compensation,
	output logic low_voltage_ohms,
	output meter_cmd_pkg::unit_t temp_unit,
	output meter_cmd_pkg::jsrc_t junction_source_select,
	output logic [15:0] sim_ref_value,
	output meter_cmd_pkg::unit_t sim_ref_unit,
	output logic rtd_user,
	output logic rate_slow,
	output logic rate_medium,
	output logic rate_fast
);
	import meter_cmd_pkg::*;

	// ==========================================================
	// Bus slave
	logic a_sel; // Data phase pending
	logic a_wr; // Pending phase is a write
	logic [7:0] a_addr; // Pending phase address
	wire addr_ok = hsel & htrans[1] & hready;
	wire wr_en = a_sel & a_wr;
	wire cmd_wr = wr_en & (a_addr == `ADDR_CMD);
	wire err_wr = wr_en & (a_addr == `ADDR_ERROR);
	wire rd_reading = addr_ok & ~hwrite & (haddr[7:0] == `ADDR_READING);

	// Address phase capture; the slave never stalls
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			a_sel <= 1'b0;
			a_wr <= 1'b0;
			a_addr <= 8'h00;
			hreadyout <= 1'b0;
			hresp <= 1'b0;
		end else begin
			a_sel <= addr_ok;
			a_wr <= hwrite;
			a_addr <= haddr[7:0];
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// ==========================================================
	// State
	state_t state; // Measuring or idle
	logic [7:0] samples; // Sample count
	logic [7:0] remaining; // Samples left in this initiation
	trig_t trig_src; // Trigger source
	logic store_lock; // Buffer holds stored readings
	logic valid; // Latest reading usable by fetch
	logic fresh; // Latest reading not yet returned as fresh
	logic [31:0] latest; // Last reading
	logic [31:0] answer; // Query answer word
	logic answer_ready; // Answer waiting to be read
	logic read_pending; // Read query awaits its completion
	logic err_flag; // Error raised since last clear
	logic [15:0] err_code; // Last error code
	logic [3:0] buf_count; // Readings in buffer
	logic [31:0] buffer [0:`BUF_DEPTH-1]; // Multi-sample readings
	func_t chan_func [0:4]; // Function per slot first channel
	logic [4:0] chan_offset_compensation; // Offset compensation per channel
	logic offset_compensation_set; // Unlisted offset compensation
	logic lvohm_set; // Unlisted low-voltage ohms
	logic [15:0] aper_ms; // Gate time in ms
	logic [15:0] rtd_coef [0:3]; // User RTD coefficients

	// ==========================================================
	// Command decode
	wire cmd_t op = cmd_t'(hwdata[`OP_MSB:`OP_LSB]);
	wire [23:0] arg = hwdata[23:0];
	wire [2:0] slot = hwdata[`SLOT_MSB:`SLOT_LSB];
	wire clist = hwdata[`CLIST_BIT];
	wire slot_ok = slot < `SLOT_COUNT;
	wire func_t slot_fn = slot_ok ? chan_func[slot] : FN_DCV;
	wire [7:0] quote = hwdata[`QUOTE_MSB:`QUOTE_LSB];
	wire quote_ok = (quote == `QUOTE_SINGLE) | (quote == `QUOTE_DOUBLE);
	wire idle = state == ST_IDLE;
	wire multi_lock = store_lock & (samples > 8'h01);
	logic c_err; // Command refused
	logic [15:0] c_code; // Code for refused command
	logic c_start; // Command starts an initiation
	logic c_pend; // Command waits for completion
	logic c_ans; // Command answers at once

	// Checks per opcode; refusals leave settings unchanged
	always_comb begin
		c_err = 1'b0;
		c_code = `ERR_SYNTAX;
		c_start = 1'b0;
		c_pend = 1'b0;
		c_ans = 1'b0;
		unique case (op)
			OP_NOP, OP_RANGE, OP_STORE, OP_RESET, OP_PRESET, OP_JSIM, OP_RTDCOEF,
			OP_APER: begin
				c_err = 1'b0;
			end
			OP_FUNC: begin
				c_err = ~quote_ok | (arg[3:0] >= `FUNC_COUNT) | (clist & ~slot_ok);
			end
			OP_OFFSET_COMPENSATION: begin
				// Scan channel must already be four-wire
				c_err = clist & (~slot_ok | slot_fn != FN_OHM4);
				c_code = `ERR_SCANFUNC;
			end
			OP_LVOHM: begin
				c_err = clist & ~slot_ok;
			end
			OP_JSRC: begin
				c_err = (arg[1:0] > 2'h2) | (arg[1:0] == 2'h2 & (~slot_ok |
					(slot_fn != FN_TEMP_THERM & slot_fn != FN_TEMP_RTD4)));
				c_code = (arg[1:0] > 2'h2) ? `ERR_SYNTAX : `ERR_CONFLICT;
			end
			OP_UNIT: begin
				c_err = ~(arg == `UNIT_C | arg == `UNIT_CEL | arg == `UNIT_F |
					arg == `UNIT_FAR | arg == `UNIT_K);
			end
			OP_CONT: begin
				c_err = arg[0] & (samples > 8'h01);
				c_code = `ERR_CONFLICT;
			end
			OP_SAMPLE: begin
				c_err = (arg[7:0] == 8'h00) | (auto_rearm & arg[7:0] > 8'h01);
				c_code = (arg[7:0] == 8'h00) ? `ERR_SYNTAX : `ERR_CONFLICT;
			end
			OP_TRIGSRC: begin
				c_err = arg[1:0] > 2'h2;
			end
			OP_INIT: begin
				c_err = ~idle | multi_lock;
				c_code = ~idle ? `ERR_INIT_IGN : `ERR_MEMORY;
				c_start = ~c_err;
			end
			OP_LATEST: begin
				c_ans = 1'b1;
			end
			OP_FRESH: begin
				c_err = ~fresh;
				c_code = `ERR_STALE;
				c_ans = fresh;
			end
			OP_FETCH: begin
				c_err = ~valid;
				c_code = `ERR_STALE;
				c_ans = valid;
			end
			OP_READ: begin
				// Busy read still answers at the next completion
				c_err = (trig_src != TS_IMM) | multi_lock | ~idle;
				c_code = (trig_src != TS_IMM) ? `ERR_DEADLOCK :
					multi_lock ? `ERR_MEMORY : `ERR_INIT_IGN;
				c_pend = (trig_src == TS_IMM) & ~multi_lock;
				c_start = c_pend & idle;
			end
			default: begin
				c_err = 1'b1;
			end
		endcase
	end

	wire do_cmd = cmd_wr & ~c_err;
	wire auto_go = auto_rearm & idle & ~(cmd_wr & c_start);
	wire start = (cmd_wr & c_start) | auto_go;
	wire last_done = ~idle & meas_done & (remaining == 8'h01);
	wire invalidate = do_cmd & (op == OP_RANGE | (op == OP_FUNC & ~clist));

	// ==========================================================
	// Trigger state machine
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= ST_IDLE;
			remaining <= 8'h00;
			meas_start <= 1'b0;
		end else begin
			meas_start <= start;
			unique case (state)
				ST_IDLE: begin
					if (start) begin
						state <= ST_MEAS;
						remaining <= samples;
					end
				end
				ST_MEAS: begin
					if (meas_done) begin
						remaining <= remaining - 8'h01;
						if (last_done)
							state <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// Reading store, validity and freshness
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			latest <= 32'h00000000;
			valid <= 1'b0;
			fresh <= 1'b0;
			buf_count <= 4'h0;
		end else begin
			if (~idle & meas_done) begin
				latest <= meas_value;
				valid <= 1'b1;
				fresh <= 1'b1;
				if (samples > 8'h01 && buf_count < `BUF_DEPTH)
					buf_count <= buf_count + 4'h1;
			end else begin
				if (start | invalidate)
					valid <= 1'b0;
				if (start)
					buf_count <= 4'h0;
				if (do_cmd & op == OP_FRESH)
					fresh <= 1'b0;
			end
		end
	end

	// Buffer words, written at the running count
	always_ff @(posedge hclk) begin
		if (~idle & meas_done & samples > 8'h01 & buf_count < `BUF_DEPTH)
			buffer[buf_count[2:0]] <= meas_value;
	end

	// Answers and errors; a new event beats a clear in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			answer <= 32'h00000000;
			answer_ready <= 1'b0;
			read_pending <= 1'b0;
			err_flag <= 1'b0;
			err_code <= `ERR_NONE;
		end else begin
			if (do_cmd & c_ans) begin
				answer <= latest;
				answer_ready <= 1'b1;
			end else if (read_pending & ~idle & meas_done) begin
				answer <= meas_value;
				answer_ready <= 1'b1;
			end else if (rd_reading) begin
				answer_ready <= 1'b0;
			end
			if (cmd_wr & c_pend)
				read_pending <= 1'b1;
			else if (~idle & meas_done)
				read_pending <= 1'b0;
			if (cmd_wr & c_err) begin
				err_flag <= 1'b1;
				err_code <= c_code;
			end else if (err_wr) begin
				err_flag <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Configuration settings
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			auto_rearm <= 1'b0;
			samples <= `RST_SAMPLES;
			trig_src <= TS_IMM;
			store_lock <= 1'b0;
			cur_func <= FN_DCV;
			temp_unit <= U_CEL;
			aper_ms <= `APER_RST_MS;
			offset_compensation_set <= 1'b0;
			lvohm_set <= 1'b0;
		end else if (do_cmd) begin
			unique case (op)
				OP_RESET: begin
					auto_rearm <= 1'b0;
					samples <= `RST_SAMPLES;
					trig_src <= TS_IMM;
				end
				OP_PRESET: begin
					auto_rearm <= 1'b1;
					samples <= `RST_SAMPLES;
					trig_src <= TS_IMM;
				end
				OP_CONT: auto_rearm <= arg[0];
				OP_SAMPLE: samples <= arg[7:0];
				OP_TRIGSRC: trig_src <= trig_t'(arg[1:0]);
				OP_STORE: store_lock <= arg[0];
				OP_FUNC: begin
					if (!clist)
						cur_func <= func_t'(arg[3:0]);
				end
				// Whole code compared: CELSIUS_CODE and FAHRENHEIT_CODE begin with the letters of C and F
				OP_UNIT: temp_unit <= (arg == `UNIT_C || arg == `UNIT_CEL) ? U_CEL :
					(arg == `UNIT_K) ? U_KEL : U_FAR;
				OP_APER: aper_ms <= arg[15:0];
				OP_OFFSET_COMPENSATION: begin
					if (!clist)
						offset_compensation_set <= arg[0];
				end
				OP_LVOHM: begin
					if (!clist)
						lvohm_set <= arg[0];
				end
				default: begin
				end
			endcase
		end
	end

	// Per-channel table and temperature settings
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < 5; i++)
				chan_func[i] <= FN_DCV;
			chan_offset_compensation <= 5'h00;
			junction_source_select <= JS_SIM;
			sim_ref_value <= 16'h0000;
			sim_ref_unit <= U_CEL;
			rtd_user <= 1'b0;
			for (int i = 0; i < 4; i++)
				rtd_coef[i] <= 16'h0000;
		end else if (do_cmd) begin
			if (op == OP_FUNC && clist)
				chan_func[slot] <= func_t'(arg[3:0]);
			if (op == OP_OFFSET_COMPENSATION && clist)
				chan_offset_compensation[slot] <= arg[0];
			if (op == OP_JSRC)
				junction_source_select <= jsrc_t'(arg[1:0]);
			if (op == OP_JSIM) begin
				sim_ref_value <= arg[15:0];
				sim_ref_unit <= temp_unit;
			end
			if (op == OP_RTDCOEF) begin
				rtd_coef[arg[17:16]] <= arg[15:0];
				rtd_user <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Registered indicator outputs
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rate_slow <= 1'b0;
			rate_medium <= 1'b0;
			rate_fast <= 1'b0;
			offset_compensation <= 1'b0;
			low_voltage_ohms <= 1'b0;
			reading_available_bit <= 1'b0;
		end else begin
			rate_slow <= aper_ms == `APER_SLOW_MS;
			rate_medium <= aper_ms == `APER_MED_MS;
			rate_fast <= aper_ms == `APER_FAST_MS;
			offset_compensation <= offset_compensation_set & (cur_func == FN_OHM4);
			low_voltage_ohms <= lvohm_set & (cur_func == FN_OHM4);
			reading_available_bit <= valid;
		end
	end

	// ==========================================================
	// Read data, registered at the end of the address phase
	wire [31:0] status_word = {4'h0, buf_count, samples, 6'h00, chan_offset_compensation[0], store_lock,
		answer_ready, fresh, err_flag, valid, 2'h0, auto_rearm, ~idle};
	wire [31:0] rd_mux = (haddr[7:0] == `ADDR_STATUS) ? status_word :
		(haddr[7:0] == `ADDR_ERROR) ? {16'h0000, err_code} :
		(haddr[7:0] == `ADDR_READING) ? answer :
		(haddr[7:5] == `ADDR_BUF_HI) ? buffer[haddr[4:2]] : 32'h00000000;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hrdata <= 32'h00000000;
		else if (addr_ok & ~hwrite)
			hrdata <= rd_mux;
	end

	// ==========================================================
	// Checks
	property p_init_busy;
		@(posedge hclk) disable iff (!hresetn)
		cmd_wr & op == OP_INIT & ~idle |=> err_flag & err_code == `ERR_INIT_IGN & ~meas_start;
	endproperty
	a_init_busy: assert property (p_init_busy) else $error("busy init not refused");
	property p_fresh_once;
		@(posedge hclk) disable iff (!hresetn)
		do_cmd & op == OP_FRESH & ~meas_done |=> ~fresh;
	endproperty
	a_fresh_once: assert property (p_fresh_once) else $error("fresh reread allowed");
	property p_fetch_none;
		@(posedge hclk) disable iff (!hresetn)
		cmd_wr & op == OP_FETCH & ~valid & idle & ~auto_rearm |=>
			err_code == `ERR_STALE & ~meas_start & $stable(answer);
	endproperty
	a_fetch_none: assert property (p_fetch_none) else $error("fetch without reading");
	property p_deadlock;
		@(posedge hclk) disable iff (!hresetn)
		cmd_wr & op == OP_READ & trig_src != TS_IMM & ~auto_rearm |=>
			err_code == `ERR_DEADLOCK & ~meas_start;
	endproperty
	a_deadlock: assert property (p_deadlock) else $error("read deadlock missed");
	property p_locked;
		@(posedge hclk) disable iff (!hresetn)
		cmd_wr & op == OP_INIT & idle & multi_lock |=> err_code == `ERR_MEMORY;
	endproperty
	a_locked: assert property (p_locked) else $error("locked init accepted");
	property p_no_trigger;
		@(posedge hclk) disable iff (!hresetn)
		cmd_wr & (op == OP_LATEST | op == OP_FRESH) & ~auto_rearm & idle |=> ~meas_start;
	endproperty
	a_no_trigger: assert property (p_no_trigger) else $error("query triggered");
	property p_rate;
		@(posedge hclk) disable iff (!hresetn)
		do_cmd & op == OP_APER & arg[15:0] == `APER_MED_MS |=> ##1
			rate_medium & ~rate_slow & ~rate_fast;
	endproperty
	a_rate: assert property (p_rate) else $error("rate indicator wrong");
	property p_rearm;
		@(posedge hclk) disable iff (!hresetn)
		do_cmd & (op == OP_RESET | op == OP_PRESET) |=> auto_rearm == $past(op == OP_PRESET);
	endproperty
	a_rearm: assert property (p_rearm) else $error("rearm mode wrong");
	property p_scan_offset_compensation;
		@(posedge hclk) disable iff (!hresetn)
		cmd_wr & op == OP_OFFSET_COMPENSATION & clist & slot_fn != FN_OHM4 |=> err_code == `ERR_SCANFUNC;
	endproperty
	a_scan_offset_compensation: assert property (p_scan_offset_compensation) else $error("offset_compensation scan check");
	property p_rtd;
		@(posedge hclk) disable iff (!hresetn)
		cmd_wr & op == OP_RTDCOEF |=> rtd_user;
	endproperty
	a_rtd: assert property (p_rtd) else $error("user rtd not selected");
endmodule

/* File: logic/meter_cmd_params.svh */
// Constants of the reading, trigger and fetch command logic.
// Assumes inclusion by the bench and the top module; definitions only.
//
// Behaviour
// - Function name quoted by single or double quotes
// - Offset compensation on non-four-wire channel: error +700
// - Unlisted ohms options apply once four-wire selected
// - External junction needs thermistor or RTD channel
// - Simulated junction value uses present units
// - Any coefficient write selects user RTD type
// - Gate time lights slow, medium, fast or none
// - Unit codes C, CELSIUS_CODE, F, FAHRENHEIT_CODE, K decoded
// - Initiate in one-shot runs sample count measurements
// - Initiate while measuring ignored, error -213
// - Latest and fresh queries never trigger measurements
// - Fresh reading returned once, else error -230
// - Fetch returns latest; multiple readings buffered
// - Sample count above one only when not rearming
// - Read query is initiate then fetch
// - Stored buffer locks multi-sample initiate and read, -225
// - Fetch without reading errors -230, never triggers
// - Reading invalidated by trigger, range or function
// - Reset disables rearm, preset enables it
// - Read with bus or external trigger: deadlock
`ifndef METER_CMD_PARAMS_SVH
`define METER_CMD_PARAMS_SVH

// ==========================================================
// Register byte offsets (low eight address bits)
`define ADDR_CMD 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_ERROR 8'h08
`define ADDR_READING 8'h0c
`define ADDR_BUF_HI 3'h1
`define BUF_DEPTH 8

// ==========================================================
// Command word fields
`define OP_MSB 31
`define OP_LSB 24
`define QUOTE_MSB 23
`define QUOTE_LSB 16
`define SLOT_MSB 11
`define SLOT_LSB 9
`define CLIST_BIT 8

// ==========================================================
// Error codes, 16-bit two's complement
`define ERR_NONE 16'h0000
`define ERR_SCANFUNC 16'h02bc
`define ERR_CONFLICT 16'hff23
`define ERR_INIT_IGN 16'hff2b
`define ERR_DEADLOCK 16'hff2a
`define ERR_MEMORY 16'hff1f
`define ERR_STALE 16'hff1a
`define ERR_SYNTAX 16'hff9a

// ==========================================================
// Decode constants and reset values
`define QUOTE_SINGLE 8'h27
`define QUOTE_DOUBLE 8'h22
`define UNIT_C 24'h000043
`define UNIT_CEL 24'h43454c
`define UNIT_F 24'h000046
`define UNIT_FAR 24'h464152
`define UNIT_K 24'h00004b
`define APER_SLOW_MS 16'h03e8
`define APER_MED_MS 16'h0064
`define APER_FAST_MS 16'h000a
`define APER_RST_MS 16'h03e8
`define FUNC_COUNT 4'hc
`define SLOT_COUNT 3'h5
`define RST_SAMPLES 8'h01

`endif

/* File: logic/meter_cmd_pkg.sv */
// Types shared by the command logic: opcodes, functions and modes.
// Assumes the params header is on the include path.
package meter_cmd_pkg;
	// Command opcodes, value is the position in this list
	typedef enum logic [7:0] {OP_NOP, OP_FUNC, OP_OFFSET_COMPENSATION, OP_LVOHM, OP_JSRC, OP_JSIM,
		OP_RTDCOEF, OP_APER, OP_UNIT, OP_CONT, OP_SAMPLE, OP_TRIGSRC, OP_INIT,
		OP_LATEST, OP_FRESH, OP_FETCH, OP_READ, OP_RESET, OP_PRESET, OP_RANGE,
		OP_STORE} cmd_t;
	// Measurement functions
	typedef enum logic [3:0] {FN_DCV, FN_ACV, FN_DCI, FN_ACI, FN_OHM2, FN_OHM4,
		FN_FREQ, FN_PER, FN_TEMP_TC, FN_TEMP_THERM, FN_TEMP_RTD4, FN_CONT} func_t;
	typedef enum logic [1:0] {U_CEL, U_FAR, U_KEL} unit_t;
	typedef enum logic [1:0] {TS_IMM, TS_BUS, TS_EXT} trig_t;
	typedef enum logic [1:0] {JS_SIM, JS_INT, JS_EXT} jsrc_t;
	typedef enum logic {ST_IDLE, ST_MEAS} state_t;
endpackage
